// ===== src/otp_lock_pkg.sv
/*
 Constants and types shared by the OTP region and lock register logic:
 command codes, register field positions, region geometry, FSM states.
 Assumes nothing of its surroundings.
*/
package otp_lock_pkg;

   // Command codes
   localparam logic [7:0] OP_RD_LOCK = 8'h2b;
   localparam logic [7:0] OP_WR_LOCK = 8'h2f;
   localparam logic [7:0] OP_ENTER = 8'hb1;
   localparam logic [7:0] OP_EXIT = 8'hc1;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_PROG = 8'h02;

   // Lock status register layout
   localparam int LOCK_FACT_BIT = 0;
   localparam int LOCK_CUST_BIT = 1;
   localparam logic [7:0] LOCK_RESET = 8'h00;

   // Region geometry: 4096 bits as 512 bytes
   localparam int OTP_AW = 9;
   localparam int OTP_DEPTH = 512;
   localparam logic [8:0] SN_LAST_ADDR = 9'h00f;
   localparam logic [8:0] OTP_LAST_ADDR = 9'h1ff;

   // Serial framing
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_OP = 6'h02,
      ST_ADDR = 6'h04,
      ST_DIN = 6'h08,
      ST_OUT = 6'h10,
      ST_SKIP = 6'h20
   } state_t;

endpackage

// ===== src/otp_store.sv
/*
 Byte array holding the one-time-programmable region.
 Assumes the command engine gates every write; reads are combinational.
*/
`timescale 1ns/10ps
module otp_store
   import otp_lock_pkg::*;
(
   // Clock
   input wire logic core_clk,
   input wire logic ce,
   // Write port
   input wire logic we,
   input wire logic [OTP_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port
   input wire logic [OTP_AW-1:0] raddr,
   output logic [7:0] rdata
);

   logic [7:0] mem [OTP_DEPTH];

   ////////////////////////////////////////////////////////////////////
   // Storage has no reset; contents stand for non-volatile cells
   always_ff @(posedge core_clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];

endmodule // otp_store

// ===== src/otp_lock_ctrl.sv
/*
 Serial command engine for the OTP region and its lock status register.
 Assumes serial pins already synchronous to core_clk, SPI mode 0 framing,
 one data line each way, and a write-enable latch kept elsewhere.
*/
// Overview of operation
// - Lock register read command is served at any time, busy or not.
// - Lock register value repeats while chip select stays low.
// - Bit 0 is read-only factory lock flag from non-volatile storage.
// - Lock register write can set bit 1, the customer lock.
// - Once locked, customer bit and region writes are ignored.
// - Lock register write needs no preceding write enable.
// - Lock write commits only if chip select rises on byte boundary.
// - Main array writes are refused while in OTP mode.
// - Region holds 512 bytes; first 16 bytes are serial number field.
// - Entry command enters OTP mode; addresses then select the region.
// - Exit command leaves OTP mode, returning to main array.
// - In OTP mode, status and lock register writes are rejected.
// - Locked region accepts only read-type commands.
`timescale 1ns/10ps
module otp_lock_ctrl
   import otp_lock_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   // Serial link
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Non-volatile lock cells
   input wire logic factory_lock_nv,
   input wire logic cust_lock_nv,
   output logic lock_nv_write,
   output logic lock_nv_value,
   // Device status
   input wire logic wel,
   output logic otp_mode,
   output logic otp_locked,
   output logic main_write_block,
   output logic sr_write_block
);

   typedef struct packed {
      state_t st;
      logic sclk;
      logic [2:0] bitc;
      logic [1:0] nbyte;
      logic [7:0] sh;
      logic [7:0] op;
      logic [OTP_AW-1:0] addr;
      logic [7:0] osh;
      logic otpm;
      logic fact;
      logic cust;
      logic init;
      logic we;
      logic [OTP_AW-1:0] wa;
      logic [7:0] wd;
      logic nvw;
   } regs_t;

   regs_t s_q;
   regs_t s_d;
   logic [7:0] mem_rdata;
   logic rise;
   logic fall;
   logic locked;
   logic commit_lock;

   // Reserved positions read as zero
   function automatic logic [7:0] lock_value(input logic f, input logic c);
      logic [7:0] v;
      v = LOCK_RESET;
      v[LOCK_FACT_BIT] = f;
      v[LOCK_CUST_BIT] = c;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Region storage, addressed by the low 9 address bits
   otp_store u_store (
      .core_clk(core_clk),
      .ce(ce),
      .we(s_q.we),
      .waddr(s_q.wa),
      .wdata(s_q.wd),
      .raddr(s_q.addr),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////
   // Edge detect on the sampled serial clock
   assign rise = spi_sclk & ~s_q.sclk;
   assign fall = ~spi_sclk & s_q.sclk;
   assign locked = s_q.fact | s_q.cust;
   // Exactly one data byte after the opcode, frame closed on the boundary
   assign commit_lock = (s_q.st == ST_DIN) && (s_q.op == OP_WR_LOCK) &&
                        (s_q.bitc == 3'h0) && (s_q.nbyte == 2'h1);

   // Next-state logic for the whole engine
   always_comb begin
      state_t cur;
      logic [7:0] bit_in;
      s_d = s_q;
      cur = (s_q.st == ST_IDLE) ? ST_OP : s_q.st;
      bit_in = {s_q.sh[6:0], spi_mosi};
      s_d.we = 1'b0;
      s_d.nvw = 1'b0;
      s_d.sclk = spi_sclk;
      // Lock cells are caught after reset release, never by the reset
      if (!s_q.init) begin
         s_d.init = 1'b1;
         s_d.fact = factory_lock_nv;
         s_d.cust = cust_lock_nv;
      end
      if (spi_cs_n) begin
         // No write enable is checked here, unlike status writes
         if (commit_lock && !locked && !s_q.otpm) begin
            s_d.cust = s_q.cust | s_q.sh[LOCK_CUST_BIT];
            s_d.nvw = s_q.sh[LOCK_CUST_BIT];
         end
         s_d.st = ST_IDLE;
         s_d.bitc = 3'h0;
         s_d.nbyte = 2'h0;
      end else begin
         s_d.st = cur;
         if (rise) begin
            s_d.sh = bit_in;
            s_d.bitc = 3'(s_q.bitc + 3'h1);
            if (cur == ST_ADDR) begin
               s_d.addr = {s_q.addr[OTP_AW-2:0], spi_mosi};
            end
            if (s_q.bitc == BIT_LAST) begin
               case (cur)
                  ST_OP: begin
                     s_d.op = bit_in;
                     s_d.nbyte = 2'h0;
                     case (bit_in)
                        OP_RD_LOCK: s_d.st = ST_OUT;
                        OP_WR_LOCK: s_d.st = ST_DIN;
                        OP_ENTER: begin
                           s_d.otpm = 1'b1;
                           s_d.st = ST_SKIP;
                        end
                        OP_EXIT: begin
                           s_d.otpm = 1'b0;
                           s_d.st = ST_SKIP;
                        end
                        OP_READ, OP_PROG: begin
                           s_d.st = s_q.otpm ? ST_ADDR : ST_SKIP;
                        end
                        default: s_d.st = ST_SKIP;
                     endcase
                  end
                  ST_ADDR: begin
                     s_d.nbyte = 2'(s_q.nbyte + 2'h1);
                     if (s_q.nbyte == ADDR_BYTES_LAST) begin
                        s_d.nbyte = 2'h0;
                        s_d.st = (s_q.op == OP_READ) ? ST_OUT : ST_DIN;
                     end
                  end
                  ST_DIN: begin
                     if (s_q.nbyte != 2'h3) begin
                        s_d.nbyte = 2'(s_q.nbyte + 2'h1);
                     end
                     if (s_q.op == OP_PROG) begin
                        // Locked region takes reads only
                        s_d.we = wel & ~locked;
                        s_d.wa = s_q.addr;
                        s_d.wd = bit_in;
                        s_d.addr = OTP_AW'(s_q.addr + 9'h001);
                     end
                  end
                  default: ;
               endcase
            end
         end else if (fall && cur == ST_OUT) begin
            if (s_q.bitc == 3'h0) begin
               // Reload each byte boundary so the value streams on
               if (s_q.op == OP_RD_LOCK) begin
                  s_d.osh = lock_value(s_q.fact, s_q.cust);
               end else begin
                  s_d.osh = mem_rdata;
                  s_d.addr = OTP_AW'(s_q.addr + 9'h001);
               end
            end else begin
               s_d.osh = {s_q.osh[6:0], 1'b0};
            end
         end
      end
   end

   // State register; clock enable freezes everything
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign spi_miso = s_q.osh[7];
   assign spi_miso_oe = (s_q.st == ST_OUT);
   assign otp_mode = s_q.otpm;
   assign otp_locked = locked;
   // The host program path consults these before touching the main array and the status register
   assign main_write_block = s_q.otpm;
   assign sr_write_block = s_q.otpm;
   assign lock_nv_write = s_q.nvw;
   assign lock_nv_value = s_q.cust;

   ////////////////////////////////////////////////////////////////////
   // Assertions
   property p_lock_load;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && !spi_cs_n && fall && s_q.st == ST_OUT && s_q.op == OP_RD_LOCK &&
       s_q.bitc == 3'h0) |=> (s_q.osh == lock_value(s_q.fact, s_q.cust));
   endproperty
   a_lock_load: assert property (p_lock_load) else $error("lock value not loaded");

   property p_stream;
      @(posedge core_clk) disable iff (!rst_n)
      (ce && !spi_cs_n && fall && s_q.st == ST_OUT && s_q.bitc != 3'h0) |=>
         (s_q.osh[7] == $past(s_q.osh[6]));
   endproperty
   a_stream: assert property (p_stream) else $error("output did not shift");

   property p_fact_stable;
      @(posedge core_clk) disable iff (!rst_n)
      (s_q.init && $past(s_q.init)) |-> $stable(s_q.fact);
   endproperty
   a_fact_stable: assert property (p_fact_stable) else $error("factory bit changed");

   property p_cust_sticky;
      @(posedge core_clk) disable iff (!rst_n)
      (s_q.init && s_q.cust) |=> s_q.cust;
   endproperty
   a_cust_sticky: assert property (p_cust_sticky) else $error("customer lock cleared");

   property p_no_locked_prog;
      @(posedge core_clk) disable iff (!rst_n)
      (s_q.init && locked) |=> !s_q.we;
   endproperty
   a_no_locked_prog: assert property (p_no_locked_prog) else $error("locked region written");

   property p_lock_commit;
      @(posedge core_clk) disable iff (!rst_n)
      lock_nv_write |-> (s_q.cust && $past(commit_lock) && !$past(s_q.otpm));
   endproperty
   a_lock_commit: assert property (p_lock_commit) else $error("bad lock commit");

   property p_main_block;
      @(posedge core_clk) disable iff (!rst_n)
      s_q.we |-> (main_write_block && sr_write_block);
   endproperty
   a_main_block: assert property (p_main_block) else $error("region write while unblocked");

   property p_enter;
      @(posedge core_clk) disable iff (!rst_n)
      $rose(s_q.otpm) |-> (s_q.op == OP_ENTER && s_q.st == ST_SKIP);
   endproperty
   a_enter: assert property (p_enter) else $error("OTP mode entered without entry code");

   property p_exit;
      @(posedge core_clk) disable iff (!rst_n)
      $fell(s_q.otpm) |-> (s_q.op == OP_EXIT && s_q.st == ST_SKIP);
   endproperty
   a_exit: assert property (p_exit) else $error("OTP mode left without exit code");

endmodule // otp_lock_ctrl

// ===== bench/otp_host_model.sv
/*
 Host controller model: SPI mode 0 frames, MSB first, one data lane.
 Assumes the device samples on sclk rise and shifts out on sclk fall.
*/
`timescale 1ns/10ps
module otp_host_model (
   // Clock
   input wire logic core_clk,
   // Serial link
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One frame of n whole bits; each level is held several core cycles
   task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx = '0;
      @(posedge core_clk) spi_cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge core_clk);
         spi_sclk <= 1'b0;
         spi_mosi <= tx[i];
         repeat (3) @(posedge core_clk);
         @(negedge core_clk) rx[i] = spi_miso;
         @(posedge core_clk) spi_sclk <= 1'b1;
         repeat (2) @(posedge core_clk);
      end
      // Clock stands low outside frames
      @(posedge core_clk) spi_sclk <= 1'b0;
      @(posedge core_clk) begin
         spi_cs_n <= 1'b1;
         spi_mosi <= ~spi_mosi; // Released line shows no stale value
      end
      repeat (3) @(posedge core_clk);
   endtask
endmodule // otp_host_model

// ===== bench/otp_lock_ctrl_tb_top.sv
/*
 Self-checking bench for the OTP lock engine with an integer model.
 Assumes the host model in otp_host_model and the shared package.
*/
`timescale 1ns/10ps
module otp_lock_ctrl_tb_top;
   import otp_lock_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wel = 1'b0;
   logic ce = 1'b1;
   logic fact_nv = 1'b0;
   logic cust_nv = 1'b0;
   logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
   logic lock_nv_write, lock_nv_value, otp_mode, otp_locked, main_write_block, sr_write_block;
   logic [63:0] rx;
   int error_cnt = 0;
   int checks = 0;
   int nvw_cnt = 0;
   int oe_cnt = 0;
   int nvw_m = 0;
   int fact_m = 0;
   int cust_m = 0;
   int mode_m = 0;
   int mem_m [int];
   int adr [4] = '{14, 15, 511, 0};

   always #2 core_clk = ~core_clk;
   // Pulse and drive-enable counters, sampled mid-cycle where outputs are settled
   always @(negedge core_clk) begin
      if (lock_nv_write === 1'b1) nvw_cnt++;
      if (spi_miso_oe === 1'b1) oe_cnt++;
   end

   otp_host_model i_otp_host_model (.core_clk(core_clk), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   otp_lock_ctrl i_otp_lock_ctrl (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .factory_lock_nv(fact_nv), .cust_lock_nv(cust_nv),
      .lock_nv_write(lock_nv_write), .lock_nv_value(lock_nv_value), .wel(wel),
      .otp_mode(otp_mode), .otp_locked(otp_locked), .main_write_block(main_write_block),
      .sr_write_block(sr_write_block));
   ////////////////////////////////////////////////////////////////////////////
   // Compare, report and close
   task automatic chk(input logic [15:0] got, input int exp, input string what);
      checks++;
      if (got !== 16'(exp)) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("Checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Commands with model updates; the lock byte is repeated twice per read
   task automatic lock_rd();
      int o;
      o = oe_cnt;
      i_otp_host_model.xfer(24, {40'h0, OP_RD_LOCK, 16'h0}, rx);
      chk(rx[15:0], (2 * cust_m + fact_m) * 257, "lock byte");
      chk(16'(otp_locked), (cust_m | fact_m), "locked flag");
      chk(16'(oe_cnt > o), 1, "drive enable in frame");
      chk(16'(spi_miso_oe), 0, "drive enable after frame");
   endtask
   // A frozen engine (clock enable low) must take nothing from the frame
   task automatic lock_wr(input int n, input logic [7:0] d);
      int o;
      o = oe_cnt;
      i_otp_host_model.xfer(n, 64'({OP_WR_LOCK, d}) >> (16 - n), rx);
      if (ce && n == 16 && mode_m == 0 && fact_m == 0 && cust_m == 0 && d[1]) begin
         cust_m = 1;
         nvw_m++;
      end
      chk(16'(nvw_cnt), nvw_m, "persist pulses");
      chk(16'(lock_nv_value), cust_m, "customer lock");
      chk(16'(oe_cnt - o), 0, "drive enable on write");
   endtask
   task automatic op(input logic [7:0] c);
      i_otp_host_model.xfer(8, 64'(c), rx);
      mode_m = (c == OP_ENTER) ? 1 : (c == OP_EXIT) ? 0 : mode_m;
      chk(16'({otp_mode, main_write_block, sr_write_block}), mode_m * 7, "mode");
   endtask
   task automatic prog(input int a, input logic [7:0] d);
      i_otp_host_model.xfer(40, {24'h0, OP_PROG, 24'(a), d}, rx);
      if (mode_m == 1 && wel && fact_m == 0 && cust_m == 0) mem_m[a] = d;
   endtask
   task automatic rd(input int a);
      i_otp_host_model.xfer(48, {16'h0, OP_READ, 24'(a), 16'h0}, rx);
      chk(rx[15:0], mem_m[a] * 256 + mem_m[(a + 1) % 512], "region read");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'h6c640967));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      lock_rd();
      op(OP_ENTER);
      lock_wr(16, 8'h02);
      @(posedge core_clk) wel <= 1'b1;
      for (int i = 0; i < 4; i++) prog(adr[i], 8'($urandom));
      @(posedge core_clk) wel <= 1'b0;
      prog(14, 8'($urandom));
      rd(14);
      rd(511);
      op(OP_EXIT);
      // Program outside OTP mode goes to the main array, never the region
      @(posedge core_clk) wel <= 1'b1;
      prog(14, 8'($urandom));
      @(posedge core_clk) wel <= 1'b0;
      lock_wr(15, 8'h02);
      lock_wr(16, 8'h01);
      lock_rd();
      @(posedge core_clk) ce <= 1'b0;
      lock_wr(16, 8'h02);
      @(posedge core_clk) ce <= 1'b1;
      lock_wr(16, 8'h02);
      lock_rd();
      op(OP_ENTER);
      @(posedge core_clk) wel <= 1'b1;
      prog(15, 8'($urandom));
      rd(14);
      lock_wr(16, 8'h00);
      op(OP_EXIT);
      // Second reset with both lock cells set
      @(posedge core_clk) begin
         rst_n <= 1'b0;
         fact_nv <= 1'b1;
         cust_nv <= 1'b1;
      end
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      fact_m = 1;
      repeat (2) @(posedge core_clk);
      lock_rd();
      finish_test();
   end
   // Watchdog against a hung run
   initial begin
      repeat (60000) @(posedge core_clk);
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      finish_test();
   end
endmodule // otp_lock_ctrl_tb_top
